//--- logic/fire_panel_map.sv
`timescale 1ns/10ps
module fire_panel_map (
  input wire logic clk,
  input wire logic rst,
  input wire logic role_master_pin,
  input wire logic [15:0] detector_block_offset,
  input wire logic [15:0] equipment_block_offset,
  input wire logic [15:0] unit_id_offset,
  input wire logic [7:0] system_status,
  input wire logic [7:0] fault_disable_flags,
  input wire logic det_upd_valid,
  input wire logic [11:0] det_upd_num,
  input wire fire_map_pkg::det_status_t det_upd_status,
  input wire logic eq_upd_valid,
  input wire logic [8:0] eq_upd_num,
  input wire fire_map_pkg::equip_status_t eq_upd_status,
  input wire fire_map_pkg::reg_req_t reg_req,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  output logic push_valid,
  output logic [15:0] push_addr,
  output logic [15:0] push_data,
  input wire logic push_ready,
  output fire_map_pkg::panel_cmd_t panel_cmd,
  output logic panel_cmd_valid,
  input wire logic panel_cmd_done,
  output logic busy
);

  // ****************************************************************
  // Storage and helpers
  // ****************************************************************
  logic [15:0] det_mem [0:2047];
  logic [15:0] eq_mem [0:255];

  // Flags whether addr falls in [start, start+words) and returns its word index in idx.
  function automatic logic in_window(input logic [15:0] addr,
                                     input logic [15:0] start,
                                     input logic [15:0] words,
                                     output logic [15:0] idx);
    logic [16:0] diff;
    diff = {1'b0, addr} - {1'b0, start};
    idx = diff[15:0];
    return !diff[16] && (diff[15:0] < words);
  endfunction : in_window

  // ****************************************************************
  // Role pin synchroniser
  // ****************************************************************
  logic role_s1_r, role_s2_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      role_s1_r <= 1'b0;
      role_s2_r <= 1'b0;
    end else begin
      role_s1_r <= role_master_pin;
      role_s2_r <= role_s1_r;
    end
  end

  // ****************************************************************
  // Status memories
  // ****************************************************************
  // A sweep after reset zeroes both maps; the push scan waits for it,
  // but a register read during the sweep can expose undefined contents.
  logic clearing_r, clearing_nxt;
  logic [10:0] clr_idx_r, clr_idx_nxt;
  logic [7:0] det_byte, eq_byte;

  always_comb begin
    clearing_nxt = clearing_r;
    clr_idx_nxt = clearing_r ? clr_idx_r + 11'h001 : clr_idx_r;
    if (clr_idx_r == 11'h7ff) begin
      clearing_nxt = 1'b0;
    end
    det_byte = {3'h0, det_upd_status};
    eq_byte = eq_upd_status;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clearing_r <= 1'b1;
      clr_idx_r <= 11'h000;
    end else begin
      clearing_r <= clearing_nxt;
      clr_idx_r <= clr_idx_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (clearing_r) begin
      det_mem[clr_idx_r] <= 16'h0000;
      eq_mem[clr_idx_r[7:0]] <= 16'h0000;
    end else begin
      if (det_upd_valid) begin
        if (det_upd_num[0]) begin
          det_mem[det_upd_num[11:1]][7:0] <= det_byte;
        end else begin
          det_mem[det_upd_num[11:1]][15:8] <= det_byte;
        end
      end
      if (eq_upd_valid) begin
        if (eq_upd_num[0]) begin
          eq_mem[eq_upd_num[8:1]][7:0] <= eq_byte;
        end else begin
          eq_mem[eq_upd_num[8:1]][15:8] <= eq_byte;
        end
      end
    end
  end

  // ****************************************************************
  // Holding registers and command engine
  // ****************************************************************
  typedef enum {ST_IDLE, ST_WAIT} cmd_state_t;
  cmd_state_t state_r, state_nxt;
  logic [15:0] cmd_r, cmd_nxt;
  logic [15:0] time_hi_r, time_hi_nxt;
  logic [15:0] time_lo_r, time_lo_nxt;
  fire_map_pkg::panel_cmd_t pcmd_r, pcmd_nxt;
  logic pvalid_r, pvalid_nxt;
  logic busy_r, busy_nxt;
  logic hold_wr;
  logic [15:0] num_field, uid, target, max_uid, eq_word;
  logic [16:0] tdiff;
  logic is_det, is_eq, keep, eq_dis;
  fire_map_pkg::cmd_kind_t kind;

  always_comb begin
    hold_wr = reg_req.wr && !reg_req.input_space;
    state_nxt = state_r;
    cmd_nxt = cmd_r;
    time_hi_nxt = time_hi_r;
    time_lo_nxt = time_lo_r;
    pcmd_nxt = pcmd_r;
    pvalid_nxt = 1'b0;
    busy_nxt = busy_r;
    is_det = 1'b0;
    is_eq = 1'b0;
    num_field = 16'h0000;
    kind = fire_map_pkg::K_NONE;
    // The whole decode looks at cmd_r, time_hi_r and time_lo_r of one
    // and the same cycle, so a command never pairs with stale data.
    case (cmd_r)
      fire_map_pkg::CODE_SILENCE: kind = fire_map_pkg::K_SILENCE;
      fire_map_pkg::CODE_RESET: kind = fire_map_pkg::K_RESET;
      fire_map_pkg::CODE_INIT: kind = fire_map_pkg::K_INIT;
      fire_map_pkg::CODE_SET_TIME: kind = fire_map_pkg::K_SET_TIME;
      default: begin
        // Unknown codes, including any read-time request, fall out.
        num_field = {4'h0, cmd_r[11:0]};
        is_det = 1'b1;
        case (cmd_r[15:12])
          fire_map_pkg::NIB_DET_DISABLE: kind = fire_map_pkg::K_DET_DISABLE;
          fire_map_pkg::NIB_DET_LEGACY: kind = fire_map_pkg::K_DET_DISABLE;
          fire_map_pkg::NIB_DET_ENABLE: kind = fire_map_pkg::K_DET_ENABLE;
          fire_map_pkg::NIB_DET_INHIBIT: kind = fire_map_pkg::K_DET_INHIBIT;
          fire_map_pkg::NIB_DET_UNINHIBIT: begin
            kind = fire_map_pkg::K_DET_UNINHIBIT;
          end
          default: is_det = 1'b0;
        endcase
        if (!is_det) begin
          num_field = {7'h00, cmd_r[8:0]};
          is_eq = 1'b1;
          case (cmd_r[15:9])
            fire_map_pkg::EQ_ACTIVATE: kind = fire_map_pkg::K_EQ_ACTIVATE;
            fire_map_pkg::EQ_DEACTIVATE: begin
              kind = fire_map_pkg::K_EQ_DEACTIVATE;
            end
            fire_map_pkg::EQ_DISABLE: kind = fire_map_pkg::K_EQ_DISABLE;
            fire_map_pkg::EQ_ENABLE: kind = fire_map_pkg::K_EQ_ENABLE;
            default: is_eq = 1'b0;
          endcase
        end
      end
    endcase
    // A zero number field means the identifier sits in register 2.
    uid = (num_field == 16'h0000) ? time_hi_r : num_field;
    tdiff = {1'b0, uid} - {1'b0, unit_id_offset};
    target = tdiff[15:0];
    max_uid = is_det ? equipment_block_offset
                     : fire_map_pkg::EQ_MAX_UNIT;
    keep = (kind != fire_map_pkg::K_NONE);
    if (is_det || is_eq) begin
      // The detector maximum only guards the short form; the long form is the
      // documented way past it.
      if (tdiff[16] || (num_field != 16'h0000 && uid > max_uid)) begin
        keep = 1'b0;
      end
      if (is_eq && target > fire_map_pkg::EQ_MAX_UNIT) begin
        keep = 1'b0;
      end
    end
    eq_word = eq_mem[target[8:1]];
    eq_dis = target[0] ? eq_word[3] : eq_word[11];
    if ((kind == fire_map_pkg::K_EQ_ACTIVATE ||
         kind == fire_map_pkg::K_EQ_DEACTIVATE) && eq_dis) begin
      keep = 1'b0;
    end
    case (state_r)
      ST_IDLE: begin
        if (cmd_r != fire_map_pkg::CMD_RESET_VAL && !clearing_r) begin
          cmd_nxt = fire_map_pkg::CMD_RESET_VAL;
          if (keep) begin
            pcmd_nxt.kind = kind;
            pcmd_nxt.unit = (is_det || is_eq) ? target : 16'h0000;
            pcmd_nxt.seconds = {time_hi_r, time_lo_r};
            pvalid_nxt = 1'b1;
            busy_nxt = 1'b1;
            state_nxt = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (panel_cmd_done) begin
          busy_nxt = 1'b0;
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // A host write lands even in the cycle the engine clears the word.
    if (hold_wr) begin
      case (reg_req.addr)
        fire_map_pkg::CMD_REG: cmd_nxt = reg_req.wdata;
        fire_map_pkg::TIME_HI_REG: time_hi_nxt = reg_req.wdata;
        fire_map_pkg::TIME_LO_REG: time_lo_nxt = reg_req.wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cmd_r <= 16'h0000;
      time_hi_r <= 16'h0000;
      time_lo_r <= 16'h0000;
      pcmd_r <= '0;
      pvalid_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cmd_r <= cmd_nxt;
      time_hi_r <= time_hi_nxt;
      time_lo_r <= time_lo_nxt;
      pcmd_r <= pcmd_nxt;
      pvalid_r <= pvalid_nxt;
      busy_r <= busy_nxt;
    end
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  logic [15:0] status_word;
  logic [15:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [15:0] ridx;
  logic [15:0] det_start, eq_start;

  always_comb begin
    status_word = {fault_disable_flags, system_status};
    status_word[fire_map_pkg::BUSY_BIT] = busy_r || clearing_r;
    det_start = fire_map_pkg::MAP_BASE + detector_block_offset;
    eq_start = fire_map_pkg::MAP_BASE + equipment_block_offset;
    rdata_nxt = 16'h0000;
    rvalid_nxt = reg_req.rd;
    ridx = 16'h0000;
    if (reg_req.rd) begin
      if (!reg_req.input_space) begin
        case (reg_req.addr)
          fire_map_pkg::CMD_REG: rdata_nxt = cmd_r;
          fire_map_pkg::TIME_HI_REG: rdata_nxt = time_hi_r;
          fire_map_pkg::TIME_LO_REG: rdata_nxt = time_lo_r;
          default: rdata_nxt = 16'h0000;
        endcase
      end else if (reg_req.addr == fire_map_pkg::STATUS_REG) begin
        rdata_nxt = status_word;
      end else if (in_window(reg_req.addr, det_start,
                             fire_map_pkg::DET_WORDS, ridx)) begin
        rdata_nxt = det_mem[ridx[10:0]];
      end else if (in_window(reg_req.addr, eq_start,
                             fire_map_pkg::EQ_WORDS, ridx)) begin
        rdata_nxt = eq_mem[ridx[7:0]];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // ****************************************************************
  // Master push scan
  // ****************************************************************
  // The scan visits the status word, every detector word and every
  // equipment word in turn; a slow partner simply slows the loop.
  logic [11:0] scan_r, scan_nxt;
  logic pv_r, pv_nxt;
  logic [15:0] pa_r, pa_nxt, pd_r, pd_nxt;
  logic [11:0] eidx;

  always_comb begin
    scan_nxt = scan_r;
    pv_nxt = pv_r;
    pa_nxt = pa_r;
    pd_nxt = pd_r;
    eidx = scan_r - 12'h801;
    if (pv_r && push_ready) begin
      pv_nxt = 1'b0;
    end else if (!pv_r && role_s2_r && !clearing_r) begin
      pv_nxt = 1'b1;
      if (scan_r == 12'h000) begin
        pa_nxt = fire_map_pkg::STATUS_REG;
        pd_nxt = status_word;
      end else if (scan_r <= 12'h800) begin
        pa_nxt = det_start + {5'h00, scan_r[10:0] - 11'h001};
        pd_nxt = det_mem[scan_r[10:0] - 11'h001];
      end else begin
        pa_nxt = eq_start + {8'h00, eidx[7:0]};
        pd_nxt = eq_mem[eidx[7:0]];
      end
      scan_nxt = (scan_r == fire_map_pkg::SCAN_LAST) ? 12'h000
                                                     : scan_r + 12'h001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scan_r <= 12'h000;
      pv_r <= 1'b0;
      pa_r <= 16'h0000;
      pd_r <= 16'h0000;
    end else begin
      scan_r <= scan_nxt;
      pv_r <= pv_nxt;
      pa_r <= pa_nxt;
      pd_r <= pd_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign push_valid = pv_r;
  assign push_addr = pa_r;
  assign push_data = pd_r;
  assign panel_cmd = pcmd_r;
  assign panel_cmd_valid = pvalid_r;
  assign busy = busy_r;

endmodule : fire_panel_map

//--- logic/fire_map_pkg.sv
package fire_map_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [15:0] STATUS_REG = 16'h0001;
  localparam logic [15:0] CMD_REG = 16'h0001;
  localparam logic [15:0] TIME_HI_REG = 16'h0002;
  localparam logic [15:0] TIME_LO_REG = 16'h0003;
  localparam logic [15:0] MAP_BASE = 16'h0002;
  localparam logic [15:0] DET_WORDS = 16'h0800;
  localparam logic [15:0] EQ_WORDS = 16'h0100;
  localparam logic [15:0] CMD_RESET_VAL = 16'h0000;
  localparam int BUSY_BIT = 12;
  localparam logic [11:0] SCAN_LAST = 12'h900;
  localparam logic [15:0] EQ_MAX_UNIT = 16'h01ff;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [15:0] CODE_SILENCE = 16'h1000;
  localparam logic [15:0] CODE_RESET = 16'h2000;
  localparam logic [15:0] CODE_INIT = 16'h2100;
  localparam logic [15:0] CODE_SET_TIME = 16'h3000;
  localparam logic [3:0] NIB_DET_DISABLE = 4'h4;
  localparam logic [3:0] NIB_DET_ENABLE = 4'h5;
  localparam logic [3:0] NIB_DET_INHIBIT = 4'h6;
  localparam logic [3:0] NIB_DET_UNINHIBIT = 4'h7;
  localparam logic [3:0] NIB_DET_LEGACY = 4'h8;
  localparam logic [6:0] EQ_ACTIVATE = 7'h70;
  localparam logic [6:0] EQ_DEACTIVATE = 7'h71;
  localparam logic [6:0] EQ_DISABLE = 7'h72;
  localparam logic [6:0] EQ_ENABLE = 7'h73;

  // Two-bit field encodings of the equipment byte.
  localparam logic [1:0] FIELD_OFF = 2'h0;
  localparam logic [1:0] FIELD_ON = 2'h1;
  localparam logic [1:0] DOOR_TRANSIT = 2'h2;
  localparam logic [1:0] EXT_OVERRIDE_REL = 2'h3;

  typedef enum logic [3:0] {
    K_NONE, K_SILENCE, K_RESET, K_INIT, K_SET_TIME,
    K_DET_DISABLE, K_DET_ENABLE, K_DET_INHIBIT, K_DET_UNINHIBIT,
    K_EQ_ACTIVATE, K_EQ_DEACTIVATE, K_EQ_DISABLE, K_EQ_ENABLE
  } cmd_kind_t;

  typedef struct packed {
    logic inhibit;
    logic disabled;
    logic fault;
    logic prewarn;
    logic alarm;
  } det_status_t;

  typedef struct packed {
    logic [1:0] equip_state;
    logic [1:0] relay_drive;
    logic disabled;
    logic fault;
    logic [1:0] activation;
  } equip_status_t;

  typedef struct packed {
    cmd_kind_t kind;
    logic [15:0] unit;
    logic [31:0] seconds;
  } panel_cmd_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic input_space;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

endpackage : fire_map_pkg

//--- testbench/fire_panel_map_assertions.sv
`timescale 1ns/10ps
module fire_panel_map_assertions (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] system_status,
  input wire fire_map_pkg::reg_req_t reg_req,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic push_valid,
  input wire logic [15:0] push_addr,
  input wire logic [15:0] push_data,
  input wire logic push_ready,
  input wire fire_map_pkg::panel_cmd_t panel_cmd,
  input wire logic panel_cmd_valid,
  input wire logic panel_cmd_done,
  input wire logic busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_status_rd;
    reg_req.rd && reg_req.input_space &&
      reg_req.addr == fire_map_pkg::STATUS_REG;
  endsequence
  property p_rd_answer;
    reg_req.rd |=> reg_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("no read answer");
  property p_rvalid_cause;
    reg_rvalid |-> $past(reg_req.rd);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause) else $error("stray rvalid");
  property p_status_low;
    s_status_rd |=> reg_rdata[7:0] == $past(system_status);
  endproperty
  a_status_low: assert property (p_status_low) else $error("status byte");
  property p_status_busy;
    s_status_rd ##0 busy |=> reg_rdata[fire_map_pkg::BUSY_BIT];
  endproperty
  a_status_busy: assert property (p_status_busy) else $error("busy bit");
  property p_busy_hold;
    busy && !panel_cmd_done |=> busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped");
  property p_new_after_idle;
    panel_cmd_valid |-> busy && !$past(busy);
  endproperty
  a_new_after_idle: assert property (p_new_after_idle) else $error("overlap");
  property p_cmd_pulse;
    panel_cmd_valid |=> !panel_cmd_valid;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("command repeated");
  property p_cmd_frozen;
    $changed(panel_cmd) |-> panel_cmd_valid;
  endproperty
  a_cmd_frozen: assert property (p_cmd_frozen) else $error("command moved");
  property p_push_hold;
    push_valid && !push_ready |=>
      push_valid && $stable(push_addr) && $stable(push_data);
  endproperty
  a_push_hold: assert property (p_push_hold) else $error("push not held");
  property p_push_drop;
    push_valid && push_ready |=> !push_valid;
  endproperty
  a_push_drop: assert property (p_push_drop) else $error("push not dropped");
endmodule : fire_panel_map_assertions

bind fire_panel_map fire_panel_map_assertions i_fire_panel_map_assertions (
  .clk(clk), .rst(rst), .system_status(system_status), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .push_valid(push_valid),
  .push_addr(push_addr), .push_data(push_data), .push_ready(push_ready),
  .panel_cmd(panel_cmd), .panel_cmd_valid(panel_cmd_valid),
  .panel_cmd_done(panel_cmd_done), .busy(busy));

//--- testbench/plc_push_sink.sv
`timescale 1ns/10ps
module plc_push_sink (
  input wire logic clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic push_valid,
  input wire logic [15:0] push_addr,
  input wire logic [15:0] push_data,
  output logic push_ready,
  output logic [15:0] got_addr,
  output logic [15:0] got_data,
  output logic [15:0] got_n
);
  logic [1:0] slow_r;
  // A busy slave takes a write only every fourth cycle when stalling.
  assign push_ready = !rst && (!stall || slow_r == 2'h3);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slow_r <= 2'h0;
      got_n <= 16'h0000;
      got_addr <= 16'h0000;
      got_data <= 16'h0000;
    end else begin
      slow_r <= slow_r + 2'h1;
      if (push_valid && push_ready) begin
        got_n <= got_n + 16'h0001;
        got_addr <= push_addr;
        got_data <= push_data;
      end
    end
  end
endmodule : plc_push_sink

//--- testbench/fire_panel_map_test.sv
`timescale 1ns/10ps
module fire_panel_map_test;
  logic clk, rst, role, det_v, eq_v, done, stall, rv, pv, pr, cv, busy;
  logic [11:0] det_n;
  logic [8:0] eq_n;
  fire_map_pkg::det_status_t det_s;
  fire_map_pkg::equip_status_t eq_s;
  fire_map_pkg::reg_req_t reg_req;
  fire_map_pkg::panel_cmd_t pc;
  logic [15:0] rdata, pa, pd, g_a, g_d, g_n;
  int error_cnt = 0;
  int check_count = 0;

  fire_panel_map i_fire_panel_map (.clk(clk), .rst(rst),
    .role_master_pin(role), .detector_block_offset(16'h0000),
    .equipment_block_offset(16'h0800), .unit_id_offset(16'h0001),
    .system_status(8'h01), .fault_disable_flags(8'h03),
    .det_upd_valid(det_v), .det_upd_num(det_n), .det_upd_status(det_s),
    .eq_upd_valid(eq_v), .eq_upd_num(eq_n), .eq_upd_status(eq_s),
    .reg_req(reg_req), .reg_rdata(rdata), .reg_rvalid(rv),
    .push_valid(pv), .push_addr(pa), .push_data(pd), .push_ready(pr),
    .panel_cmd(pc), .panel_cmd_valid(cv), .panel_cmd_done(done),
    .busy(busy));
  plc_push_sink i_plc_push_sink (.clk(clk), .rst(rst), .stall(stall),
    .push_valid(pv), .push_addr(pa), .push_data(pd), .push_ready(pr),
    .got_addr(g_a), .got_data(g_d), .got_n(g_n));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_req = '{1'b1, 1'b0, 1'b0, a, d};
    @(negedge clk);
    reg_req = '0;
  endtask : wr
  task rd(input logic sp, input logic [15:0] a, output logic [15:0] d);
    @(negedge clk);
    reg_req = '{1'b0, 1'b1, sp, a, 16'h0000};
    @(negedge clk);
    // The answer stands for one cycle only, so take it before it drops.
    chk(rv, 1'b1);
    d = rdata;
    reg_req = '0;
  endtask : rd
  task upd(input logic dt, input logic [11:0] n, input logic [7:0] s);
    @(negedge clk);
    {det_v, eq_v, det_n, eq_n, det_s, eq_s} = {dt, !dt, n, n[8:0], s[4:0], s};
    @(negedge clk);
    {det_v, eq_v} = 2'b00;
  endtask : upd
  // Every accepted command ends with the done pulse so the next one is legal.
  task cmd(input logic [15:0] w, input logic ok, input logic [3:0] k,
           input logic [15:0] u, input logic cu);
    int i;
    logic [15:0] d;
    wr(fire_map_pkg::CMD_REG, w);
    for (i = 0; i < 8 && cv !== 1'b1; i++) @(negedge clk);
    chk(cv === 1'b1, ok);
    if (ok) begin
      chk(pc.kind, k);
      if (cu) chk(pc.unit, u);
      rd(1'b1, fire_map_pkg::STATUS_REG, d);
      chk(d, 16'h1301);
    end
    rd(1'b0, fire_map_pkg::CMD_REG, d);
    chk(d, 16'h0000);
    done = ok;
    @(negedge clk);
    done = 1'b0;
    for (i = 0; i < 8 && busy !== 1'b0; i++) @(negedge clk);
    chk(busy, 1'b0);
  endtask : cmd

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_sweep;
    logic [15:0] d;
    rd(1'b1, fire_map_pkg::STATUS_REG, d);
    chk(d, 16'h1301);
    repeat (2060) @(negedge clk);
    rd(1'b1, fire_map_pkg::STATUS_REG, d);
    chk(d, 16'h0301);
  endtask : t_sweep
  task t_map;
    logic [15:0] d;
    upd(1'b1, 12'h000, 8'h01);
    upd(1'b1, 12'h001, 8'h1f);
    upd(1'b1, 12'hffe, 8'h04);
    upd(1'b1, 12'hfff, 8'h10);
    upd(1'b0, 12'h000, 8'h95);
    upd(1'b0, 12'h001, 8'h62);
    upd(1'b0, 12'h1ff, 8'hc1);
    rd(1'b1, 16'h0002, d);
    chk(d, 16'h011f);
    rd(1'b1, 16'h0801, d);
    chk(d, 16'h0410);
    rd(1'b1, 16'h0802, d);
    chk(d, 16'h9562);
    rd(1'b1, 16'h0901, d);
    chk(d, 16'h00c1);
    rd(1'b1, 16'h0a00, d);
    chk(d, 16'h0000);
  endtask : t_map
  task t_codes;
    int i;
    logic [15:0] w [12];
    logic [3:0] k [12];
    // Expected kinds follow the order of the command kind enumeration.
    w = '{16'h1000, 16'h2000, 16'h2100, 16'h4005, 16'h5005, 16'h6005,
          16'h7005, 16'h8005, 16'he005, 16'he205, 16'he405, 16'he605};
    k = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h5, 4'h9, 4'ha,
          4'hb, 4'hc};
    for (i = 0; i < 12; i++) cmd(w[i], 1'b1, k[i], 16'h0004, i > 2);
  endtask : t_codes
  task t_time;
    wr(fire_map_pkg::TIME_HI_REG, 16'h386d);
    wr(fire_map_pkg::TIME_LO_REG, 16'h4380);
    cmd(fire_map_pkg::CODE_SET_TIME, 1'b1, 4'h4, 16'h0000, 1'b0);
    chk(pc.seconds, 32'h386d4380);
  endtask : t_time
  task t_range;
    cmd(16'h4fff, 1'b0, 4'h5, 16'h0000, 1'b0);
    cmd(16'h4800, 1'b1, 4'h5, 16'h07ff, 1'b1);
    wr(fire_map_pkg::TIME_HI_REG, 16'h0c00);
    cmd(16'h4000, 1'b1, 4'h5, 16'h0bff, 1'b1);
    wr(fire_map_pkg::TIME_HI_REG, 16'h0000);
    cmd(16'h4000, 1'b0, 4'h5, 16'h0000, 1'b0);
    upd(1'b0, 12'h007, 8'h08);
    cmd(16'he008, 1'b0, 4'h9, 16'h0000, 1'b0);
  endtask : t_range
  task t_push;
    int i;
    chk(g_n, 16'h0000);
    role = 1'b1;
    stall = 1'b1;
    for (i = 0; i < 300 && g_n < 16'h0001; i++) @(negedge clk);
    chk(g_a, 16'h0001);
    chk(g_d, 16'h0301);
    for (i = 0; i < 300 && g_n < 16'h0002; i++) @(negedge clk);
    chk(g_a, 16'h0002);
    chk(g_d, 16'h011f);
    role = 1'b0;
  endtask : t_push

  task end_of_test;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // The sweep and about twenty commands need far fewer than 30000 cycles.
  initial begin
    #3000000;
    error_cnt++;
    end_of_test;
  end
  initial begin
    {rst, role, det_v, eq_v, done, stall} = 6'b100000;
    {det_n, eq_n, det_s, eq_s, reg_req} = '0;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    t_sweep;
    t_map;
    t_codes;
    t_time;
    t_range;
    t_push;
    end_of_test;
  end
endmodule : fire_panel_map_test
